// ### design/iasc_delay_line.sv
// fixed-depth word pipeline advanced on sample events
`timescale 1ns/10ps
module iasc_delay_line #(
  parameter int WIDTH = iasc_pkg::WORD_W,
  parameter int DEPTH = iasc_pkg::PIPE_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // words
  input wire logic shift_en,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import iasc_pkg::*;

  logic [WIDTH-1:0] stage_reg [DEPTH];
  logic [WIDTH-1:0] stage_next [DEPTH];

  // ----------------------------------------
  // stages
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      always_comb begin
        if (!shift_en) begin
          stage_next[g] = stage_reg[g];
        end else if (g == 0) begin
          stage_next[g] = din;
        end else begin
          stage_next[g] = stage_reg[(g == 0) ? 0 : g - 1];
        end
      end
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          stage_reg[g] <= '0;
        end else begin
          stage_reg[g] <= stage_next[g];
        end
      end
    end
  endgenerate

  assign dout = stage_reg[DEPTH-1];

endmodule // iasc_delay_line

// ### design/iasc_pkg.sv
// constants and types shared by the serial configuration block
package iasc_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int NUM_REGS = 7;
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_LOOP = 3'h1;
  localparam logic [2:0] ADDR_FACTORY_A = 3'h2;
  localparam logic [2:0] ADDR_FACTORY_B = 3'h3;
  localparam logic [2:0] ADDR_FACTORY_C = 3'h4;
  localparam logic [2:0] ADDR_TGT_CTRL = 3'h5;
  localparam logic [2:0] ADDR_TGT_CODE = 3'h6;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CHIP_SELECT_BIT = 0;
  localparam int OP_MODE_LSB = 1;
  localparam int OUTPUT_EDGE_BIT = 4;
  localparam int FAST_LOOP_BIT = 5;
  localparam int OUTPUT_FLOAT_BIT = 7;
  localparam int LOOP_OFF_BIT = 6;
  localparam int TGT_ENABLE_BIT = 0;
  localparam int TGT_RELOAD_BIT = 1;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h03;
  localparam logic [7:0] OTHER_RESET = 8'h00;
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{MODE_RESET, OTHER_RESET, OTHER_RESET,
    OTHER_RESET, OTHER_RESET, OTHER_RESET, OTHER_RESET};

  // ----------------------------------------
  // clamp loop and data path
  // ----------------------------------------
  localparam logic [9:0] FIXED_TARGET = 10'h1EC;
  localparam int PIPE_DEPTH = 9;
  localparam int WORD_W = 14;
  localparam int LOOP_SHIFT_NORMAL = 4;
  localparam int LOOP_SHIFT_FAST = 3;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_GAIN_6DB = 2'h1,
    MODE_TEST = 2'h2,
    MODE_GAIN_0DB = 2'h3
  } iasc_mode_t;

endpackage

// ### design/iasc_serial_config.sv
// serial register bank, black clamp loop and output path
`timescale 1ns/10ps

module iasc_serial_config (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial port
  input wire logic serial_clk,
  input wire logic serial_load_strobe,
  input wire logic serial_input_pin,
  // sample side
  input wire logic sample_clock,
  input wire logic black_clamp_pulse,
  input wire logic preblank_strobe,
  input wire logic [iasc_pkg::WORD_W-1:0] vin_pos_code,
  input wire logic [iasc_pkg::WORD_W-1:0] vin_neg_code,
  // data outputs
  output logic [iasc_pkg::WORD_W-1:0] data_out,
  output logic data_oe,
  // analog controls
  output iasc_pkg::iasc_mode_t op_mode,
  output logic signed [15:0] black_correction,
  output logic [9:0] clamp_target,
  output logic chip_selected
);
  import iasc_pkg::*;

  function automatic logic [WORD_W-1:0] sat14(input logic signed [17:0] v);
    if (v < 0) begin
      return '0;
    end else if (v > 18'sh03FFF) begin
      return 14'h3FFF;
    end else begin
      return v[WORD_W-1:0];
    end
  endfunction

  // ----------------------------------------
  // serial receiver in its own clock domain
  // ----------------------------------------
  iasc_stage_if st ();

  iasc_serial_rx u_rx (
    .serial_clk(serial_clk),
    .rst(rst),
    .serial_load_strobe(serial_load_strobe),
    .serial_input_pin(serial_input_pin),
    .st(st)
  );

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_s1, pin_s2;
  logic sl_s3, smp_s3;
  logic [WORD_W-1:0] pos_s1, pos_s2, neg_s1, neg_s2;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 5'h01;
      pin_s2 <= 5'h01;
      sl_s3 <= 1'h1;
      smp_s3 <= 1'h0;
      pos_s1 <= '0;
      pos_s2 <= '0;
      neg_s1 <= '0;
      neg_s2 <= '0;
    end else begin
      pin_s1 <= {preblank_strobe, black_clamp_pulse, sample_clock, 1'h0, serial_load_strobe};
      pin_s2 <= pin_s1;
      sl_s3 <= pin_s2[0];
      smp_s3 <= pin_s2[2];
      pos_s1 <= vin_pos_code;
      pos_s2 <= pos_s1;
      neg_s1 <= vin_neg_code;
      neg_s2 <= neg_s1;
    end
  end

  logic commit, smp_rise, smp_fall, clamp_on, blank_on;
  assign commit = pin_s2[0] & ~sl_s3;
  assign smp_rise = pin_s2[2] & ~smp_s3;
  assign smp_fall = ~pin_s2[2] & smp_s3;
  assign clamp_on = pin_s2[3];
  assign blank_on = pin_s2[4];

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  // staged bytes are still while the strobe is high, so they are read directly
  logic [7:0] regs_reg [NUM_REGS];
  logic [7:0] regs_next [NUM_REGS];
  logic accept;

  assign accept = commit && (st.count != 3'h0) && st.staged[0][CHIP_SELECT_BIT];

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_next[i] = regs_reg[i];
      if (accept && (3'(i) < st.count)) begin
        regs_next[i] = st.staged[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= REG_RESET[i];
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= regs_next[i];
      end
    end
  end

  logic edge_sel, fast_loop, out_float, loop_off, tgt_enable, tgt_reload;
  assign op_mode = iasc_mode_t'(regs_reg[ADDR_MODE][OP_MODE_LSB +: 2]);
  assign chip_selected = regs_reg[ADDR_MODE][CHIP_SELECT_BIT];
  assign edge_sel = regs_reg[ADDR_MODE][OUTPUT_EDGE_BIT];
  assign fast_loop = regs_reg[ADDR_MODE][FAST_LOOP_BIT];
  assign out_float = regs_reg[ADDR_MODE][OUTPUT_FLOAT_BIT];
  assign loop_off = regs_reg[ADDR_LOOP][LOOP_OFF_BIT];
  assign tgt_enable = regs_reg[ADDR_TGT_CTRL][TGT_ENABLE_BIT];
  assign tgt_reload = regs_reg[ADDR_TGT_CTRL][TGT_RELOAD_BIT];

  // ----------------------------------------
  // black target
  // ----------------------------------------
  logic [7:0] code_hold_reg, code_hold_next;
  logic [9:0] target_reg, target_next;

  always_comb begin
    code_hold_next = tgt_reload ? regs_reg[ADDR_TGT_CODE] : code_hold_reg;
    target_next = tgt_enable ? {code_hold_reg, 2'h0} : FIXED_TARGET;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      code_hold_reg <= 8'h00;
      target_reg <= FIXED_TARGET;
    end else begin
      code_hold_reg <= code_hold_next;
      target_reg <= target_next;
    end
  end

  assign clamp_target = target_reg;

  // ----------------------------------------
  // conversion and clamp loop
  // ----------------------------------------
  logic signed [15:0] corr_reg, corr_next;
  logic signed [17:0] diff, scaled;
  logic [WORD_W-1:0] word, entry;
  logic signed [15:0] err;

  always_comb begin
    diff = 18'($signed({1'h0, pos_s2})) - 18'($signed({1'h0, neg_s2}));
    scaled = (op_mode == MODE_GAIN_6DB) ? 18'(diff <<< 1) : diff;
    word = sat14(scaled + 18'(corr_reg));
    if (op_mode == MODE_STANDBY) begin
      word = '0;
    end
    entry = (blank_on && !clamp_on) ? '0 : word;
    err = $signed({6'h00, target_reg}) - $signed({2'h0, word});
    corr_next = corr_reg;
    if (loop_off) begin
      corr_next = 16'sh0000;
    end else if (smp_rise && clamp_on) begin
      corr_next = corr_reg + (fast_loop ? (err >>> LOOP_SHIFT_FAST)
                                        : (err >>> LOOP_SHIFT_NORMAL));
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      corr_reg <= 16'sh0000;
    end else begin
      corr_reg <= corr_next;
    end
  end

  assign black_correction = corr_reg;

  // ----------------------------------------
  // output pipeline
  // ----------------------------------------
  logic [WORD_W-1:0] tap, dout_reg, dout_next;
  logic upd_edge, oe_reg, oe_next;

  iasc_delay_line #(
    .WIDTH(WORD_W),
    .DEPTH(PIPE_DEPTH)
  ) u_pipe (
    .core_clk(core_clk),
    .rst(rst),
    .shift_en(smp_rise),
    .din(entry),
    .dout(tap)
  );

  always_comb begin
    upd_edge = edge_sel ? smp_fall : smp_rise;
    dout_next = upd_edge ? tap : dout_reg;
    oe_next = ~out_float;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dout_reg <= '0;
      oe_reg <= 1'h1;
    end else begin
      dout_reg <= dout_next;
      oe_reg <= oe_next;
    end
  end

  assign data_out = dout_reg;
  assign data_oe = oe_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_commit_loads_byte: assert property (accept |=> regs_reg[0] == $past(st.staged[0]))
    else $error("committed byte not loaded");
  a_no_select_ignored: assert property (commit && !st.staged[0][0] |=> $stable(regs_reg[0]))
    else $error("write accepted without chip select");
  a_regs_hold: assert property (!accept |=> $stable(regs_reg[ADDR_TGT_CODE]))
    else $error("register changed without commit");
  a_fixed_target: assert property (!tgt_enable |=> clamp_target == 10'h1EC)
    else $error("fixed target wrong");
  a_target_scale: assert property (tgt_enable |=> clamp_target == {$past(code_hold_reg), 2'h0})
    else $error("custom target not four times code");
  a_reload_gate: assert property (!tgt_reload |=> $stable(code_hold_reg))
    else $error("target taken without reload");
  a_float_outputs: assert property (out_float [*2] |-> !data_oe)
    else $error("outputs driven while floated");
  a_loop_off_zero: assert property (loop_off |=> black_correction == 16'sh0000)
    else $error("correction active while loop off");
  a_edge_update: assert property (!$stable(data_out) |-> $past(upd_edge))
    else $error("output updated on wrong edge");
  // outputs come back one edge after the float bit clears
  a_oe_restored: assert property (!out_float [*2] |-> data_oe)
    else $error("outputs floated while float bit clear");
  // the loop only moves on a detected sample rise inside a clamp pulse, or to zero when switched off
  a_corr_hold: assert property (!loop_off && !(smp_rise && clamp_on) |=> $stable(corr_reg))
    else $error("correction moved outside clamp pulse");
  a_mode_hold: assert property (!accept |=> $stable(regs_reg[ADDR_MODE]))
    else $error("mode register changed without commit");
  a_empty_refused: assert property (st.count == 3'h0 |-> !accept)
    else $error("commit taken with no complete byte");
  // preblank zeroes the entered word unless a clamp pulse overlaps it
  a_blank_entry: assert property (blank_on && !clamp_on |-> entry == '0)
    else $error("preblank word not zero");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  c_commit: cover property (accept);
  c_clamp: cover property (smp_rise && clamp_on && !loop_off);
  c_blank: cover property (smp_rise && blank_on && !clamp_on);
  c_float: cover property (out_float && !data_oe);
  c_reload: cover property (tgt_reload && tgt_enable);

endmodule // iasc_serial_config

// ### design/iasc_serial_rx.sv
// serial shifter running on the host serial clock
`timescale 1ns/10ps
module iasc_serial_rx (
  // serial pins
  input wire logic serial_clk,
  input wire logic rst,
  input wire logic serial_load_strobe,
  input wire logic serial_input_pin,
  // staged bytes
  iasc_stage_if.rx st
);
  import iasc_pkg::*;

  // ----------------------------------------
  // frame state, cleared while the strobe is high except the byte count and the staged bytes
  // ----------------------------------------
  logic frame_rst;
  logic [6:0] shift_reg, shift_next;
  logic [2:0] bit_reg, bit_next;
  logic [2:0] addr_reg, addr_next;
  logic fresh_reg;
  logic [2:0] count_reg, count_next;
  logic [7:0] staged_reg [NUM_REGS];
  logic [7:0] byte_full;
  logic byte_done;

  assign frame_rst = rst | serial_load_strobe;
  assign byte_full = {serial_input_pin, shift_reg};
  assign byte_done = (bit_reg == 3'h7) && (addr_reg < 3'(NUM_REGS));

  always_comb begin
    shift_next = {serial_input_pin, shift_reg[6:1]};
    bit_next = bit_reg + 3'h1;
    addr_next = addr_reg;
    if (bit_reg == 3'h7 && addr_reg != 3'h7) begin
      addr_next = addr_reg + 3'h1;
    end
    count_next = fresh_reg ? 3'h0 : count_reg;
    if (byte_done) begin
      count_next = addr_reg + 3'h1;
    end
  end

  always_ff @(posedge serial_clk or posedge frame_rst) begin
    if (frame_rst) begin
      shift_reg <= 7'h00;
      bit_reg <= 3'h0;
      addr_reg <= 3'h0;
      fresh_reg <= 1'h1;
    end else begin
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      addr_reg <= addr_next;
      fresh_reg <= 1'h0;
    end
  end

  always_ff @(posedge serial_clk or posedge rst) begin
    if (rst) begin
      count_reg <= 3'h0;
    end else begin
      count_reg <= count_next;
    end
  end

  // byte storage needs no reset: the count guards it
  always_ff @(posedge serial_clk) begin
    if (byte_done) begin
      staged_reg[addr_reg] <= byte_full;
    end
  end

  assign st.staged = staged_reg;
  assign st.count = count_reg;

endmodule // iasc_serial_rx

// ### design/iasc_stage_if.sv
// staged bytes handed from the serial clock domain to the core
`timescale 1ns/10ps
interface iasc_stage_if;
  logic [7:0] staged [iasc_pkg::NUM_REGS];
  logic [2:0] count;
  modport rx (output staged, output count);
  modport core (input staged, input count);
endinterface

// ### testbench/iasc_host_model.sv
// host model that writes the serial configuration port
`timescale 1ns/10ps
module iasc_host_model (
  // serial pins
  output logic serial_clk,
  output logic serial_load_strobe,
  output logic serial_input_pin
);
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    serial_clk = 1'b0;
    serial_load_strobe = 1'b1;
    serial_input_pin = 1'b0;
  end

  // ----------------------------------------
  // one frame: byte n to address n, lsb first; the clock runs only inside it
  // ----------------------------------------
  task automatic send_frame(input logic [55:0] bits_lsb, input int nbits);
    serial_load_strobe = 1'b0;
    #7.5;
    for (int i = 0; i < nbits; i++) begin
      serial_input_pin = bits_lsb[i];
      #7.5 serial_clk = 1'b1;
      #7.5 serial_clk = 1'b0;
    end
    #7.5 serial_load_strobe = 1'b1;
    // no hold level on the data pin, so it does not keep the last bit
    serial_input_pin = ~serial_input_pin;
    #60;
  endtask
endmodule // iasc_host_model

// ### testbench/test_imager_afe_serial_config.sv
// self-checking bench for the serial configuration block
`timescale 1ns/10ps
module test_imager_afe_serial_config;
  import iasc_pkg::*;
  typedef struct packed {
    logic [7:0] reg0;
    logic [1:0] mode;
    logic oe;
  } iasc_row_t;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sample_clock = 1'b0;
  logic run_sample = 1'b0;
  logic [2:0] phase_reg = 3'h0;
  logic black_clamp_pulse = 1'b0;
  logic preblank_strobe = 1'b0;
  logic [WORD_W-1:0] vin_pos_code = '0;
  logic [WORD_W-1:0] vin_neg_code = '0;
  logic serial_clk;
  logic serial_load_strobe;
  logic serial_input_pin;
  logic [WORD_W-1:0] data_out;
  logic data_oe;
  iasc_mode_t op_mode;
  logic signed [15:0] black_correction;
  logic [9:0] clamp_target;
  logic chip_selected;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  iasc_row_t rows [5] = '{'{8'h01, 2'h0, 1'b1}, '{8'h05, 2'h2, 1'b1}, '{8'h07, 2'h3, 1'b1},
    '{8'h83, 2'h1, 1'b0}, '{8'h03, 2'h1, 1'b1}};

  // ----------------------------------------
  // clocks and timeout
  // ----------------------------------------
  always #5 core_clk = ~core_clk;

  // sample clock of eight core cycles, running only when enabled
  always @(posedge core_clk) begin
    phase_reg <= phase_reg + 3'h1;
    if (run_sample) begin
      sample_clock <= phase_reg[2];
    end
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // instances
  // ----------------------------------------
  iasc_host_model host (
    .serial_clk(serial_clk),
    .serial_load_strobe(serial_load_strobe),
    .serial_input_pin(serial_input_pin)
  );

  iasc_serial_config uut (
    .core_clk(core_clk),
    .rst(rst),
    .serial_clk(serial_clk),
    .serial_load_strobe(serial_load_strobe),
    .serial_input_pin(serial_input_pin),
    .sample_clock(sample_clock),
    .black_clamp_pulse(black_clamp_pulse),
    .preblank_strobe(preblank_strobe),
    .vin_pos_code(vin_pos_code),
    .vin_neg_code(vin_neg_code),
    .data_out(data_out),
    .data_oe(data_oe),
    .op_mode(op_mode),
    .black_correction(black_correction),
    .clamp_target(clamp_target),
    .chip_selected(chip_selected)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic write_frame(input logic [55:0] b, input int nbits);
    host.send_frame(b, nbits);
    tick(8);
  endtask

  task automatic burst(input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r5,
    input logic [7:0] r6);
    write_frame({r6, r5, 8'h10, 8'h63, 8'h48, r1, r0}, 56);
  endtask

  task automatic wait_rises(input int n);
    repeat (n) @(posedge sample_clock);
    tick(6);
  endtask

  task automatic check_reset;
    check_val({14'h0, op_mode}, 16'h0001);
    check_val({6'h0, clamp_target}, 16'h01EC);
    check_val({15'h0, chip_selected}, 16'h0001);
    check_val({15'h0, data_oe}, 16'h0001);
    check_val(black_correction, 16'h0000);
    check_val({2'h0, data_out}, 16'h0000);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    tick(10);
    rst <= 1'b0;
    tick(4);
    check_reset();
    foreach (rows[i]) begin
      write_frame({48'h0, rows[i].reg0}, 8);
      check_val({14'h0, op_mode}, {14'h0, rows[i].mode});
      check_val({15'h0, data_oe}, {15'h0, rows[i].oe});
    end
    // deselected frame and short frame leave everything alone
    write_frame(56'h06, 8);
    check_val({14'h0, op_mode}, 16'h0001);
    write_frame(56'h07, 4);
    check_val({14'h0, op_mode}, 16'h0001);
    burst(8'h03, 8'h00, 8'h03, 8'hFF);
    check_val({6'h0, clamp_target}, 16'h03FC);
    burst(8'h03, 8'h00, 8'h01, 8'h10);
    check_val({6'h0, clamp_target}, 16'h03FC);
    burst(8'h03, 8'h00, 8'h03, 8'h00);
    check_val({6'h0, clamp_target}, 16'h0000);
    burst(8'h03, 8'h00, 8'h00, 8'h00);
    check_val({6'h0, clamp_target}, 16'h01EC);
    // sample path at 0 dB with the loop off, then with the loop on
    burst(8'h07, 8'h40, 8'h00, 8'h00);
    vin_pos_code <= 14'h0064;
    run_sample <= 1'b1;
    wait_rises(12);
    check_val({2'h0, data_out}, 16'h0064);
    @(negedge sample_clock);
    tick(1);
    vin_pos_code <= 14'h00C8;
    wait_rises(9);
    check_val({2'h0, data_out}, 16'h0064);
    wait_rises(1);
    check_val({2'h0, data_out}, 16'h00C8);
    preblank_strobe <= 1'b1;
    wait_rises(12);
    check_val({2'h0, data_out}, 16'h0000);
    black_clamp_pulse <= 1'b1;
    wait_rises(12);
    check_val({2'h0, data_out}, 16'h00C8);
    check_val(black_correction, 16'h0000);
    burst(8'h07, 8'h00, 8'h00, 8'h00);
    wait_rises(4);
    check_val({15'h0, black_correction > 16'sh0000}, 16'h0001);
    black_clamp_pulse <= 1'b0;
    preblank_strobe <= 1'b0;
    // second reset in mid-run
    rst <= 1'b1;
    tick(3);
    check_reset();
    rst <= 1'b0;
    tick(4);
    check_val({6'h0, clamp_target}, 16'h01EC);
    tally_and_finish();
  end
endmodule // test_imager_afe_serial_config
